// ---- hw/ctg_pkg.sv ----
// Shared constants and types for the cycle timing generator
package ctg_pkg;
	localparam int CLK_NS       = 10;
	localparam int STAGE_NS     = 50;
	localparam int TICK_CYC     = (STAGE_NS + CLK_NS - 1) / CLK_NS;
	localparam int LONG_NS      = 1400;
	localparam int SHORT_NS     = 1200;
	localparam int CHAIN_LEN    = LONG_NS / STAGE_NS;
	localparam int VAR_SKIP     = (LONG_NS - SHORT_NS) / STAGE_NS;
	localparam int VAR_IN       = 5;
	localparam int VAR_OUT      = VAR_IN + VAR_SKIP + 1;
	localparam int PRE_W        = 4;
	localparam logic [3:0] PRESET_PAT = 4'h3;
	localparam int TAP_P1       = 2;
	localparam int TAP_P2       = 11;
	localparam int TAP_P3       = 18;
	localparam int TAP_P4       = 26;
	localparam int TAP_STB_ON   = 3;
	localparam int TAP_READ_OFF = 5;
	localparam int TAP_WRITE_ON = 12;
	localparam int TAP_INH_ON   = 14;
	localparam int FRZ_LO       = 19;
	localparam int FRZ_HI       = 22;
	localparam int MB_LEN       = 7;
	localparam int MB_SRC_OFF   = 3;
	localparam int MB_WR_OFF    = 5;
	localparam int G_ST1        = 0;
	localparam int G_ST2        = 1;
	localparam int G_ST3        = 2;
	localparam int G_ST4        = 3;
	localparam int G_SRC        = 4;
	localparam int G_RET        = 5;
	localparam int G_STB        = 6;
	localparam int G_WR         = 7;
	localparam int G_INH        = 8;
	localparam int G_NUM        = 9;
	localparam int PIN_PRESET_N = 0;
	localparam int PIN_POWER_OK = 1;
	localparam int PIN_START_N  = 2;
	localparam int PIN_MORE_N   = 3;
	localparam int PIN_STROBE_N = 4;
	localparam int PIN_STRAP    = 5;
	localparam int PIN_FETCH    = 6;
	localparam int PIN_INDIRECT = 7;
	localparam int PIN_AUTOIDX  = 8;
	localparam int PIN_SLOW     = 9;
	localparam int PIN_IO       = 10;
	localparam int PIN_NUM      = 11;
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam int CTRL_START   = 0;
	localparam int CTRL_FORCE   = 1;
	localparam int ST_RUN       = 0;
	localparam int ST_GO        = 1;
	localparam int ST_LONG      = 2;
	localparam int ST_STALL     = 3;
	localparam int ST_TS        = 4;
	localparam int ST_PRESET    = 8;
	localparam int ST_ACK       = 9;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SEL_CTRL   = 2'b00,
		SEL_STATUS = 2'b01,
		SEL_NONE   = 2'b10
	} ctg_sel_e;
endpackage

// ---- hw/ctg_srff.sv ----
// Set/reset timing flag with a preset clamp
module ctg_srff #(
	parameter bit PRESET_VAL = 1'b0
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic preset,
	input  wire logic set_in,
	input  wire logic clr_in,
	output logic      q
);
	// Preset dominates, then set over clear
	always_ff @(posedge aclk) begin
		if (!aresetn || preset) begin
			q <= PRESET_VAL;
		end else if (set_in) begin
			q <= 1'b1;
		end else if (clr_in) begin
			q <= 1'b0;
		end
	end
endmodule

// ---- hw/ctg_sync.sv ----
// Two-flop synchroniser for a group of pin levels
module ctg_sync #(
	parameter int W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	// First stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule

// ---- hw/ctg_top.sv ----
// Cycle timing generator: shift chain, time states, pulses, memory gates, register slave
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
module ctg_top
	import ctg_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              power_preset_n,
	input  wire logic              power_ok,
	input  wire logic              mem_start_n,
	input  wire logic              more_xfer_n,
	input  wire logic              xfer_strobe_n,
	input  wire logic              long_cycle_strap,
	input  wire logic              fetch_entry,
	input  wire logic              indirect_state,
	input  wire logic              autoindex_ref,
	input  wire logic              slow_entry,
	input  wire logic              io_instruction,
	output logic                   state_one,
	output logic                   state_two,
	output logic                   state_three,
	output logic                   state_four,
	output logic                   pulse_one,
	output logic                   pulse_two,
	output logic                   pulse_three,
	output logic                   pulse_four,
	output logic                   mem_source,
	output logic                   mem_return,
	output logic                   mem_strobe,
	output logic                   mem_write,
	output logic                   mem_inhibit,
	output logic                   run
);
	localparam int PULSE_TAP [4] = '{TAP_P1, TAP_P2, TAP_P3, TAP_P4};

	if (ADDR_W < 3 || ADDR_W > 8) begin : g_chk_addr
		$error("ADDR_W must lie between 3 and 8");
	end
	if (TICK_CYC < 1 || TICK_CYC > 8) begin : g_chk_tick
		$error("Stage tick does not fit the tick counter");
	end

	logic [PIN_NUM-1:0]   pins;
	logic [PIN_NUM-1:0]   pins_s;
	logic [2:0]           tick_cnt_r;
	logic                 tick;
	logic [CHAIN_LEN-1:0] sr_r;
	logic [CHAIN_LEN-1:0] sr_nxt;
	logic [MB_LEN-1:0]    mb_r;
	logic                 run_r;
	logic                 go_r;
	logic                 long_r;
	logic                 ack_r;
	logic                 frz_run_r;
	logic                 stall_r;
	logic                 start_prev_r;
	logic                 strobe_prev_r;
	logic                 force_long_r;
	logic                 sw_start_r;
	logic [3:0]           pulse_r;
	logic [G_NUM-1:0]     g_set;
	logic [G_NUM-1:0]     g_clr;
	logic [G_NUM-1:0]     g_q;
	logic                 preset_s;
	logic                 more_act;
	logic                 start_ev;
	logic                 strobe_ev;
	logic                 st3_end;
	logic                 wr_go;
	logic                 bvalid_r;
	logic [1:0]           bresp_r;
	logic                 rvalid_r;
	logic [1:0]           rresp_r;
	logic [31:0]          rdata_r;
	logic [31:0]          status_w;
	ctg_sel_e             wsel;
	ctg_sel_e             rsel;

	function automatic ctg_sel_e decode(input logic [ADDR_W-1:0] a);
		if (a == OFF_CTRL[ADDR_W-1:0]) begin
			return SEL_CTRL;
		end else if (a == OFF_STATUS[ADDR_W-1:0]) begin
			return SEL_STATUS;
		end
		return SEL_NONE;
	endfunction

	// Leading and trailing edge of the two-stage pulse at a tap
	function automatic logic lead(input int a);
		return sr_r[a] & ~sr_r[a+1];
	endfunction

	function automatic logic trail(input int a);
		return sr_r[a] & ~sr_r[a-1];
	endfunction

	function automatic logic mlead(input int a);
		return mb_r[a] & ~mb_r[a+1];
	endfunction

	function automatic logic mtrail(input int a);
		return mb_r[a] & ~mb_r[a-1];
	endfunction

	assign pins[PIN_PRESET_N] = power_preset_n;
	assign pins[PIN_POWER_OK] = power_ok;
	assign pins[PIN_START_N]  = mem_start_n;
	assign pins[PIN_MORE_N]   = more_xfer_n;
	assign pins[PIN_STROBE_N] = xfer_strobe_n;
	assign pins[PIN_STRAP]    = long_cycle_strap;
	assign pins[PIN_FETCH]    = fetch_entry;
	assign pins[PIN_INDIRECT] = indirect_state;
	assign pins[PIN_AUTOIDX]  = autoindex_ref;
	assign pins[PIN_SLOW]     = slow_entry;
	assign pins[PIN_IO]       = io_instruction;

	ctg_sync #(
		.W(PIN_NUM)
	) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       (pins),
		.q       (pins_s)
	);

	assign preset_s  = ~pins_s[PIN_PRESET_N];
	assign start_ev  = (~pins_s[PIN_START_N] & start_prev_r) | sw_start_r;
	assign strobe_ev = ~pins_s[PIN_STROBE_N] & strobe_prev_r;
	// Only honoured during an I/O instruction, which does not change the cycle length
	assign more_act  = ~pins_s[PIN_MORE_N] & pins_s[PIN_IO];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// Synchroniser resets low, so a high here would fake an edge
			start_prev_r  <= 1'b0;
			strobe_prev_r <= 1'b0;
		end else begin
			start_prev_r  <= pins_s[PIN_START_N];
			strobe_prev_r <= pins_s[PIN_STROBE_N];
		end
	end

	// 50 ns stage tick from the 10 ns clock
	assign tick = (tick_cnt_r == 3'(TICK_CYC - 1));

	always_ff @(posedge aclk) begin
		if (!aresetn || tick) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 3'h1;
		end
	end

	// Run flag and the chain release one tick later
	always_ff @(posedge aclk) begin
		if (!aresetn || preset_s) begin
			run_r <= 1'b0;
		end else if (start_ev) begin
			run_r <= 1'b1;
		end else if (tick && lead(TAP_P3) && !pins_s[PIN_POWER_OK]) begin
			run_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || preset_s) begin
			go_r <= 1'b0;
		end else if (tick) begin
			go_r <= run_r;
		end
	end

	// Cycle-length flag; strap and software force hold it set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			long_r <= 1'b0;
		end else if (pins_s[PIN_STRAP] || force_long_r) begin
			long_r <= 1'b1;
		end else if (pins_s[PIN_FETCH] || (pins_s[PIN_INDIRECT] && !pins_s[PIN_AUTOIDX])) begin
			long_r <= 1'b0;
		end else if (pins_s[PIN_SLOW]) begin
			long_r <= 1'b1;
		end
	end

	// Chain next value: rotate, preset load, bypass, freeze
	always_comb begin
		sr_nxt = {sr_r[CHAIN_LEN-2:0], sr_r[CHAIN_LEN-1]};
		if (!go_r) begin
			sr_nxt[PRE_W-1:0] = PRESET_PAT;
		end
		if (!long_r) begin
			sr_nxt[VAR_OUT-1:VAR_IN+1] = '0;
			sr_nxt[VAR_OUT]            = sr_r[VAR_IN];
		end
		if (!frz_run_r) begin
			sr_nxt[FRZ_HI:FRZ_LO] = sr_r[FRZ_HI:FRZ_LO];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sr_r <= CHAIN_LEN'(PRESET_PAT);
		end else if (tick) begin
			sr_r <= sr_nxt;
		end
	end

	// Write-half branch never freezes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mb_r <= '0;
		end else if (tick) begin
			mb_r <= {mb_r[MB_LEN-2:0], sr_r[TAP_P3]};
		end
	end

	// Transfer flag: cleared at pulse three, re-armed by a final strobe
	always_ff @(posedge aclk) begin
		if (!aresetn || preset_s) begin
			ack_r <= 1'b1;
		end else if (strobe_ev && !more_act) begin
			ack_r <= 1'b1;
		end else if (tick && lead(TAP_P3) && more_act) begin
			ack_r <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || preset_s) begin
			frz_run_r <= 1'b1;
		end else if (tick) begin
			frz_run_r <= ack_r;
		end
	end

	// Stall pending; covers a strobe that beats the freeze
	always_ff @(posedge aclk) begin
		if (!aresetn || preset_s) begin
			stall_r <= 1'b0;
		end else if (tick && lead(TAP_P3) && more_act) begin
			stall_r <= 1'b1;
		end else if (st3_end) begin
			stall_r <= 1'b0;
		end
	end

	// Procedural so the chain read inside lead() is in the sensitivity
	always_comb begin
		st3_end = tick && ack_r && ((lead(TAP_P3) && !more_act) || stall_r);
	end

	// Set and clear taps of the state and memory flags
	always_comb begin
		g_set        = '0;
		g_clr        = '0;
		g_set[G_ST1] = tick && lead(TAP_P4);
		g_clr[G_ST1] = tick && lead(TAP_P1);
		g_set[G_ST2] = tick && lead(TAP_P1);
		g_clr[G_ST2] = tick && lead(TAP_P2);
		g_set[G_ST3] = tick && lead(TAP_P2);
		g_clr[G_ST3] = st3_end;
		g_set[G_ST4] = st3_end;
		g_clr[G_ST4] = tick && lead(TAP_P4);
		g_set[G_SRC] = tick && (lead(TAP_P1) || lead(TAP_WRITE_ON));
		g_clr[G_SRC] = tick && (lead(TAP_READ_OFF) || mlead(MB_SRC_OFF));
		g_set[G_RET] = g_set[G_SRC];
		g_clr[G_RET] = tick && (trail(TAP_READ_OFF) || mtrail(MB_SRC_OFF));
		g_set[G_STB] = tick && lead(TAP_STB_ON);
		g_clr[G_STB] = tick && lead(TAP_READ_OFF);
		g_set[G_WR]  = tick && lead(TAP_WRITE_ON);
		g_clr[G_WR]  = tick && mlead(MB_WR_OFF);
		g_set[G_INH] = tick && lead(TAP_INH_ON);
		g_clr[G_INH] = tick && mlead(MB_WR_OFF);
	end

	for (genvar i = 0; i < G_NUM; i++) begin : g_flag
		ctg_srff #(
			.PRESET_VAL(i == G_ST1)
		) u_flag (
			.aclk    (aclk),
			.aresetn (aresetn),
			.preset  (preset_s),
			.set_in  (g_set[i]),
			.clr_in  (g_clr[i]),
			.q       (g_q[i])
		);
	end

	// Pulse spans both stages around its tap; never reads past the chain end
	for (genvar p = 0; p < 4; p++) begin : g_pulse
		always_ff @(posedge aclk) begin
			if (!aresetn || preset_s) begin
				pulse_r[p] <= 1'b0;
			end else begin
				pulse_r[p] <= lead(PULSE_TAP[p]) | trail(PULSE_TAP[p]);
			end
		end
	end

	assign state_one   = g_q[G_ST1];
	assign state_two   = g_q[G_ST2];
	assign state_three = g_q[G_ST3];
	assign state_four  = g_q[G_ST4];
	assign mem_source  = g_q[G_SRC];
	assign mem_return  = g_q[G_RET];
	assign mem_strobe  = g_q[G_STB];
	assign mem_write   = g_q[G_WR];
	assign mem_inhibit = g_q[G_INH];
	assign pulse_one   = pulse_r[0];
	assign pulse_two   = pulse_r[1];
	assign pulse_three = pulse_r[2];
	assign pulse_four  = pulse_r[3];
	assign run         = run_r;

	// Register slave: one write and one read outstanding
	assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rresp   = rresp_r;
	assign s_axi_rdata   = rdata_r;
	assign wsel          = decode(s_axi_awaddr);
	assign rsel          = decode(s_axi_araddr);

	always_comb begin
		status_w                      = '0;
		status_w[ST_RUN]              = run_r;
		status_w[ST_GO]               = go_r;
		status_w[ST_LONG]             = long_r;
		status_w[ST_STALL]            = stall_r;
		status_w[ST_TS+3:ST_TS]       = g_q[G_ST4:G_ST1];
		status_w[ST_PRESET]           = preset_s;
		status_w[ST_ACK]              = ack_r;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r     <= 1'b0;
			bresp_r      <= RESP_OKAY;
			force_long_r <= 1'b0;
			sw_start_r   <= 1'b0;
		end else begin
			sw_start_r <= 1'b0;
			if (wr_go) begin
				bvalid_r <= 1'b1;
				bresp_r  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
				if (wsel == SEL_CTRL && s_axi_wstrb[0]) begin
					force_long_r <= s_axi_wdata[CTRL_FORCE];
					sw_start_r   <= s_axi_wdata[CTRL_START];
				end
			end else if (s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rresp_r  <= RESP_OKAY;
			rdata_r  <= 32'h0000_0000;
		end else if (s_axi_arvalid && !rvalid_r) begin
			rvalid_r <= 1'b1;
			unique case (rsel)
				SEL_CTRL: begin
					rdata_r <= 32'(force_long_r) << CTRL_FORCE;
					rresp_r <= RESP_OKAY;
				end
				SEL_STATUS: begin
					rdata_r <= status_w;
					rresp_r <= RESP_OKAY;
				end
				default: begin
					rdata_r <= 32'h0000_0000;
					rresp_r <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_preset_states: assert property (preset_s |=> state_one && !state_two && !state_three && !state_four)
		else $error("Preset did not clamp time states");
	a_preset_gates: assert property (preset_s |=> !mem_source && !mem_return && !mem_strobe && !mem_write
		&& !mem_inhibit)
		else $error("Preset did not clear memory gates");
	a_strap_long: assert property (pins_s[PIN_STRAP] |=> long_r)
		else $error("Strap did not hold the long cycle");
	a_fetch_short: assert property ((pins_s[PIN_FETCH] && !pins_s[PIN_STRAP] && !force_long_r) |=> !long_r)
		else $error("Fetch entry did not select the short cycle");
	a_return_lag: assert property (($fell(mem_source) && mem_return && !preset_s) |-> mem_return[*5] ##1 !mem_return)
		else $error("Return gate did not drop one stage after source");
	a_inhibit_lag: assert property (($rose(mem_write) && !preset_s) |->
		!mem_inhibit[*8] ##1 !mem_inhibit[*2] ##1 mem_inhibit)
		else $error("Inhibit did not follow write by two stages");
	a_strobe_read: assert property (mem_strobe |-> !mem_write && !mem_inhibit)
		else $error("Sense strobe outside the read half");
	a_stall_hold: assert property ((stall_r && !preset_s) |-> state_three && !state_four)
		else $error("State three left during a stall");
	a_state_order: assert property ($rose(state_four) |-> $past(state_three) && !state_three)
		else $error("State four entered out of order");
	a_freeze_next: assert property ((tick && !ack_r && !preset_s) |=> !frz_run_r)
		else $error("Chain not frozen after the stall decision");
	a_bypass_short: assert property ((tick && !long_r) |=> sr_r[VAR_OUT-1:VAR_IN+1] == '0)
		else $error("Variable section used in a short cycle");
	a_start_run: assert property ((start_ev && !preset_s) |=> run_r)
		else $error("Start request did not set run");

	c_stall: cover property (stall_r ##1 !stall_r);
	c_long: cover property (long_r && $rose(state_four));
	c_short: cover property (!long_r && $rose(state_four));
	c_pfail: cover property ($fell(run_r) && !preset_s);
endmodule

// ---- tb/ctg_periph_model.sv ----
// Far-side peripheral model for multi-transfer I/O stalls
module ctg_periph_model (
	input  wire logic       aclk,
	input  wire logic       arm,
	input  wire logic [3:0] xfers,
	input  wire logic       pulse_three,
	output logic            more_xfer_n,
	output logic            xfer_strobe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] left_r = 4'h0;
	logic [2:0] tmr_r  = 3'h0;
	logic       busy_r = 1'b0;
	logic       p3_r   = 1'b0;
	initial begin
		more_xfer_n = 1'b1;
		xfer_strobe_n = 1'b1;
	end
	always @(posedge aclk) begin
		p3_r <= pulse_three;
		if (arm) begin
			left_r <= xfers;
			more_xfer_n <= (xfers < 4'h2);
		end else if (busy_r) begin
			// Four clocks low, four high, so the pin synchroniser sees every edge
			xfer_strobe_n <= tmr_r[2];
			tmr_r <= tmr_r + 3'h1;
			if (tmr_r == 3'h7) begin
				left_r <= left_r - 4'h1;
				busy_r <= (left_r > 4'h1);
				if (left_r == 4'h2)
					more_xfer_n <= 1'b1;
			end
		end else if (pulse_three && !p3_r && left_r > 4'h1) begin
			busy_r <= 1'b1;
		end
	end
endmodule

// ---- tb/cycle_timing_generator_test.sv ----
// Self-checking bench for the cycle timing generator
module cycle_timing_generator_test
	import ctg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 10000;
	logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, power_preset_n = 1'b1, power_ok = 1'b1, arm = 1'b0;
	logic        mem_start_n = 1'b1, long_cycle_strap = 1'b0, fetch_entry = 1'b1, indirect_state = 1'b0;
	logic        autoindex_ref = 1'b0, slow_entry = 1'b0, io_instruction = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, xfers = 4'h0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, more_xfer_n, xfer_strobe_n;
	logic        state_one, state_two, state_three, state_four, pulse_one, pulse_two, pulse_three, pulse_four;
	logic        mem_source, mem_return, mem_strobe, mem_write, mem_inhibit, run;
	int          num_errors = 0, samples_checked = 0, cyc = 0;

	ctg_top DUT (
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_preset_n, .power_ok, .mem_start_n,
		.more_xfer_n, .xfer_strobe_n, .long_cycle_strap, .fetch_entry, .indirect_state, .autoindex_ref, .slow_entry,
		.io_instruction, .state_one, .state_two, .state_three, .state_four, .pulse_one, .pulse_two, .pulse_three,
		.pulse_four, .mem_source, .mem_return, .mem_strobe, .mem_write, .mem_inhibit, .run
	);
	ctg_periph_model u_periph (.aclk, .arm, .xfers, .pulse_three, .more_xfer_n, .xfer_strobe_n);

	always #5 aclk = ~aclk;

	always @(posedge aclk) begin
		cyc++;
		if (cyc == LIMIT) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!(s_axi_awready && s_axi_wready));
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, re);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] re);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check(s_axi_rdata & m, e);
		check(s_axi_rresp, re);
	endtask

	task automatic next_cycle();
		do @(posedge aclk); while (state_one !== 1'b1);
		do @(posedge aclk); while (state_one !== 1'b0);
	endtask

	// One cycle, from a state one fall to the next; t3 of zero means a stall is expected
	task automatic sweep(input int per, input int t2, input int t3);
		int         n = 0, c2 = 0, c3 = 0, c4 = 0, cp = 0, bad = 0, w = 0, wf = 0, ih = 0, sf = 0, rf = 0;
		logic [4:0] p = 5'h0C;
		logic       fell;
		do begin
			@(posedge aclk);
			n++;
			c2 += state_two;
			c3 += state_three;
			c4 += state_four;
			cp += pulse_one + pulse_two + pulse_three + pulse_four;
			bad += (mem_strobe && !state_two) + ($countones({state_one, state_two, state_three, state_four}) != 1);
			if (mem_write && !p[1]) w = n;
			if (!mem_write && p[1]) wf = n;
			if (mem_inhibit && !p[0]) ih = n;
			if (!mem_source && p[3] && sf == 0) sf = n;
			if (!mem_return && p[2] && rf == 0) rf = n;
			fell = p[4] && !state_one;
			bad += fell && !pulse_one;
			p = {state_one, mem_source, mem_return, mem_write, mem_inhibit};
		end while (!fell);
		if (t3 != 0) begin
			check(n, per);
			check(c3, t3);
			check(c4, 40);
		end else begin
			check(c3 > 35, 1);
		end
		check(c2, t2);
		check(cp, 40);
		check(bad, 0);
		check(ih - w, 10);
		check(wf - w, 60);
		check(rf - sf, 5);
	endtask

	task automatic t_reset();
		repeat (3) @(posedge aclk);
		check({state_four, state_three, state_two, state_one, run}, 5'h02);
		check({mem_source, mem_return, mem_strobe, mem_write, mem_inhibit}, 5'h00);
		rd_chk(OFF_STATUS, 32'h0000_01F3, 32'h0000_0010, RESP_OKAY);
		rd_chk(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, RESP_SLVERR);
		wr(8'h08, 32'h0000_0001, RESP_SLVERR);
		repeat (3) @(posedge aclk);
		check(run, 1'b0);
		wr(OFF_CTRL, 32'h0000_0001, RESP_OKAY);
		repeat (3) @(posedge aclk);
		check(run, 1'b1);
		next_cycle();
		sweep(120, 25, 35);
		$display("reset and start test done");
	endtask

	task automatic t_modes();
		// Fields: strap, fetch, indirect, autoindex, slow, long expected
		logic [5:0] tab [6] = '{6'h10, 6'h03, 6'h08, 6'h0F, 6'h31, 6'h10};
		foreach (tab[i]) begin
			@(posedge aclk);
			{long_cycle_strap, fetch_entry, indirect_state, autoindex_ref, slow_entry} <= tab[i][5:1];
			// The flag may change mid-cycle, so the cycle after next is the one judged
			next_cycle();
			next_cycle();
			sweep(tab[i][0] ? 140 : 120, tab[i][0] ? 45 : 25, 35);
		end
		// Software force of the long cycle, then released again
		wr(OFF_CTRL, 32'h0000_0002, RESP_OKAY);
		next_cycle();
		next_cycle();
		sweep(140, 45, 35);
		rd_chk(OFF_CTRL, 32'hFFFF_FFFF, 32'h0000_0002, RESP_OKAY);
		rd_chk(OFF_STATUS, 32'h0000_0004, 32'h0000_0004, RESP_OKAY);
		wr(OFF_CTRL, 32'h0000_0000, RESP_OKAY);
		$display("cycle mode test done");
	endtask

	task automatic t_stall();
		do @(posedge aclk); while (state_four !== 1'b1);
		arm <= 1'b1;
		xfers <= 4'h3;
		io_instruction <= 1'b1;
		@(posedge aclk);
		arm <= 1'b0;
		next_cycle();
		sweep(0, 25, 0);
		io_instruction <= 1'b0;
		sweep(120, 25, 35);
		$display("stall test done");
	endtask

	task automatic t_power();
		power_ok <= 1'b0;
		repeat (300) @(posedge aclk);
		check({run, state_one, state_two}, 3'h2);
		power_ok <= 1'b1;
		mem_start_n <= 1'b0;
		repeat (4) @(posedge aclk);
		mem_start_n <= 1'b1;
		repeat (4) @(posedge aclk);
		check(run, 1'b1);
		do @(posedge aclk); while (state_three !== 1'b1);
		power_preset_n <= 1'b0;
		repeat (5) @(posedge aclk);
		check({state_four, state_three, state_two, state_one, run, pulse_two, pulse_three}, 7'h08);
		check({mem_source, mem_return, mem_strobe, mem_write, mem_inhibit}, 5'h00);
		power_preset_n <= 1'b1;
		$display("power test done");
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_modes();
		t_stall();
		t_power();
		wrap_up();
	end
endmodule
